// file: src/sic_defines.svh
`ifndef SIC_DEFINES_SVH
`define SIC_DEFINES_SVH
`define SIC_ADDR_W 16
`define SIC_OFF_INPUT_EN 16'hffce
`define SIC_OFF_SIG_CTRL1 16'hffee
`define SIC_OFF_CSYNC_CTRL 16'hffef
`define SIC_OFF_FLAG_CLR 16'hfffe
`define SIC_OFF_SIG_CTRL2 16'hffff
`define SIC_EN_DFG 0
`define SIC_EN_DPG 1
`define SIC_EN_CFG 2
`define SIC_EN_CTL 3
`define SIC_EN_EXT 4
`define SIC_EN_CSYNC 5
`define SIC_C1_DPG_FLAG 0
`define SIC_C1_DPG_EDGE 1
`define SIC_C1_SYNC_ON 2
`define SIC_C1_CFG_BOTH 3
`define SIC_C1_CFG_DIV 4
`define SIC_C1_DFG_EDGE 5
`define SIC_C1_EXT_EDGE 6
`define SIC_C2_CFG_MAL 0
`define SIC_C2_TP_SEL 3
`define SIC_FC_CFG_CLR 3
`define SIC_FC_DPG_CLR 2
`define SIC_CFG_TIMEOUT 16'hffff
`endif

// file: src/sic_pkg.sv
package sic_pkg;
    typedef logic [7:0] sic_byte_t;
    typedef enum logic [1:0] {SIC_WAIT = 2'b00, SIC_ARMED = 2'b01} sic_mal_t;
endpackage

// file: src/sic_edge.sv
`timescale 1ns/1ps
module sic_edge
    import sic_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic sig_i,
    input wire logic en_i,
    input wire logic fall_i,
    input wire logic both_i,
    output logic hit_o
);
    logic prev_r;
    wire rise = sig_i & ~prev_r;
    wire fall = ~sig_i & prev_r;
    // enable gates detection; both-edge mode overrides polarity
    assign hit_o = en_i & (both_i ? (rise | fall) : (fall_i ? fall : rise));
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            prev_r <= 1'b0;
        else
            prev_r <= sig_i;
    end
endmodule

// file: src/sic_mal.sv
`timescale 1ns/1ps
`include "sic_defines.svh"
module sic_mal
    import sic_pkg::*;
#(
    parameter logic [15:0] TIMEOUT = `SIC_CFG_TIMEOUT
)
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic hit_i,
    output logic timeout_o
);
    sic_mal_t st_r;
    logic [15:0] cnt_r;
    // no capstan edge for TIMEOUT+1 cycles after one means malfunction
    assign timeout_o = (st_r == SIC_ARMED) && (cnt_r == TIMEOUT) && !hit_i;
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            st_r <= SIC_WAIT;
            cnt_r <= 16'h0000;
        end
        else
        begin
            case (st_r)
                SIC_WAIT:
                begin
                    cnt_r <= 16'h0000;
                    if (hit_i)
                        st_r <= SIC_ARMED;
                end
                default:
                begin
                    if (hit_i)
                        cnt_r <= 16'h0000;
                    else if (cnt_r == TIMEOUT)
                        st_r <= SIC_WAIT;
                    else
                        cnt_r <= cnt_r + 16'h0001;
                end
            endcase
        end
    end
endmodule

// file: src/sic_top.sv
// What this block does
// (RULE1) read-only flag sets when a qualifying drum-phase edge is seen
// (RULE2) write-only bit turns drum sync register off (0) or on (1)
// (RULE3) read-only capstan malfunction flag reads 1 after malfunction
// (RULE4) select bit steers register access to pulse generator a or b
// (RULE5) writing 1 to drum-phase clear bit clears its flag; 0 no effect
// (RULE6) drum and external edge selects: 0 rising, 1 falling; capstan select: 0 both edges, 1 rising; all reset to 0
`timescale 1ns/1ps
`include "sic_defines.svh"
module sic_top
    import sic_pkg::*;
#(
    parameter logic [15:0] CFG_TIMEOUT = `SIC_CFG_TIMEOUT
)
(
    input wire logic CLK_I,
    input wire logic RSTN_I,
    input wire logic [15:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    input wire logic DRUM_FREQUENCY_INPUT_I,
    input wire logic DRUM_PHASE_INPUT_I,
    input wire logic CAPSTAN_FREQUENCY_INPUT_I,
    input wire logic CONTROL_TRACK_INPUT_I,
    input wire logic EXTERNAL_INPUT_I,
    input wire logic CSYNC_INPUT_I,
    output logic DRUM_FREQ_EDGE_O,
    output logic DRUM_PHASE_EDGE_O,
    output logic CAPSTAN_EDGE_O,
    output logic CONTROL_TRACK_EDGE_O,
    output logic EXTERNAL_EDGE_O,
    output logic DRUM_SYNC_ON_O,
    output logic TIMING_PULSE_SELECT_O
);
    sic_byte_t en_r;
    sic_byte_t c1_r;
    sic_byte_t c2_r;
    sic_byte_t cs_r;
    logic dpg_flag_r;
    logic cfg_mal_r;
    logic [7:0] rdata_nxt;
    logic h_dfg, h_dpg, h_cfg, h_ctl, h_ext, mal_hit;

    wire sel_en = (ADDR_I == `SIC_OFF_INPUT_EN);
    wire sel_c1 = (ADDR_I == `SIC_OFF_SIG_CTRL1);
    wire sel_cs = (ADDR_I == `SIC_OFF_CSYNC_CTRL);
    wire sel_fc = (ADDR_I == `SIC_OFF_FLAG_CLR);
    wire sel_c2 = (ADDR_I == `SIC_OFF_SIG_CTRL2);
    wire wr_fc = WR_I & sel_fc;
    wire dpg_clr = wr_fc & WDATA_I[`SIC_FC_DPG_CLR]; // [RULE5]
    wire cfg_clr = wr_fc & WDATA_I[`SIC_FC_CFG_CLR];

    // enable bit 1 disables the input
    sic_edge u_dfg (.clk_i(CLK_I), .rstn_i(RSTN_I), // [RULE6]
        .sig_i(DRUM_FREQUENCY_INPUT_I), .en_i(~en_r[`SIC_EN_DFG]),
        .fall_i(c1_r[`SIC_C1_DFG_EDGE]), .both_i(1'b0), .hit_o(h_dfg));
    sic_edge u_dpg (.clk_i(CLK_I), .rstn_i(RSTN_I), // [RULE6]
        .sig_i(DRUM_PHASE_INPUT_I), .en_i(~en_r[`SIC_EN_DPG]),
        .fall_i(c1_r[`SIC_C1_DPG_EDGE]), .both_i(1'b0), .hit_o(h_dpg));
    sic_edge u_cfg (.clk_i(CLK_I), .rstn_i(RSTN_I),
        .sig_i(CAPSTAN_FREQUENCY_INPUT_I), .en_i(~en_r[`SIC_EN_CFG]),
        .fall_i(1'b0), .both_i(~c1_r[`SIC_C1_CFG_BOTH]), .hit_o(h_cfg));
    sic_edge u_ctl (.clk_i(CLK_I), .rstn_i(RSTN_I),
        .sig_i(CONTROL_TRACK_INPUT_I), .en_i(~en_r[`SIC_EN_CTL]),
        .fall_i(1'b0), .both_i(1'b0), .hit_o(h_ctl));
    sic_edge u_ext (.clk_i(CLK_I), .rstn_i(RSTN_I), // [RULE6]
        .sig_i(EXTERNAL_INPUT_I), .en_i(~en_r[`SIC_EN_EXT]),
        .fall_i(c1_r[`SIC_C1_EXT_EDGE]), .both_i(1'b0), .hit_o(h_ext));
    sic_mal #(.TIMEOUT(CFG_TIMEOUT)) u_mal (.clk_i(CLK_I), .rstn_i(RSTN_I),
        .hit_i(h_cfg), .timeout_o(mal_hit));

    // read mux; write-only bits read 0
    always_comb
    begin
        rdata_nxt = 8'h00;
        if (sel_en)
            rdata_nxt = {2'b00, en_r[5:0]};
        else if (sel_c1)
            rdata_nxt = {7'h00, dpg_flag_r}; // [RULE1]
        else if (sel_cs)
            rdata_nxt = {cs_r[7:6], 6'h00};
        else if (sel_c2)
            rdata_nxt = {4'h0, c2_r[3:1], cfg_mal_r}; // [RULE3] [RULE4]
    end

    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            en_r <= 8'h00;
            c1_r <= 8'h00;
            c2_r <= 8'h00;
            cs_r <= 8'h00;
        end
        else if (WR_I)
        begin
            if (sel_en)
                en_r <= {2'b00, WDATA_I[5:0]};
            else if (sel_c1)
                c1_r <= {1'b0, WDATA_I[6:1], 1'b0}; // [RULE2] [RULE6]
            else if (sel_cs)
                cs_r <= {WDATA_I[7:5], 5'h00};
            else if (sel_c2)
                c2_r <= {4'h0, WDATA_I[3:1], 1'b0}; // [RULE4]
        end
    end

    // flags: a set in the clear cycle wins
    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            dpg_flag_r <= 1'b0;
            cfg_mal_r <= 1'b0;
        end
        else
        begin
            if (h_dpg)
                dpg_flag_r <= 1'b1; // [RULE1]
            else if (dpg_clr)
                dpg_flag_r <= 1'b0; // [RULE5]
            if (mal_hit)
                cfg_mal_r <= 1'b1; // [RULE3]
            else if (cfg_clr)
                cfg_mal_r <= 1'b0;
        end
    end

    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            RDATA_O <= 8'h00;
            DRUM_FREQ_EDGE_O <= 1'b0;
            DRUM_PHASE_EDGE_O <= 1'b0;
            CAPSTAN_EDGE_O <= 1'b0;
            CONTROL_TRACK_EDGE_O <= 1'b0;
            EXTERNAL_EDGE_O <= 1'b0;
            DRUM_SYNC_ON_O <= 1'b0;
            TIMING_PULSE_SELECT_O <= 1'b0;
        end
        else
        begin
            RDATA_O <= RD_I ? rdata_nxt : 8'h00;
            DRUM_FREQ_EDGE_O <= h_dfg;
            DRUM_PHASE_EDGE_O <= h_dpg;
            CAPSTAN_EDGE_O <= h_cfg;
            CONTROL_TRACK_EDGE_O <= h_ctl;
            EXTERNAL_EDGE_O <= h_ext;
            DRUM_SYNC_ON_O <= c1_r[`SIC_C1_SYNC_ON]; // [RULE2]
            TIMING_PULSE_SELECT_O <= c2_r[`SIC_C2_TP_SEL]; // [RULE4]
        end
    end

    a_dpg_flag_set: assert property (@(posedge CLK_I) // [RULE1]
        disable iff (!RSTN_I) h_dpg |=> dpg_flag_r)
        else $error("drum phase flag not set");
    a_dpg_flag_clr: assert property (@(posedge CLK_I) // [RULE5]
        disable iff (!RSTN_I) dpg_clr && !h_dpg |=> !dpg_flag_r)
        else $error("drum phase flag not cleared");
    a_dpg_flag_keep: assert property (@(posedge CLK_I) // [RULE5]
        disable iff (!RSTN_I) dpg_flag_r && !dpg_clr |=> dpg_flag_r)
        else $error("drum phase flag lost");
    a_sync_bit_out: assert property (@(posedge CLK_I) // [RULE2]
        disable iff (!RSTN_I) WR_I && sel_c1 |=> ##1
        DRUM_SYNC_ON_O == $past(WDATA_I[2], 2))
        else $error("sync enable wrong");
    a_tp_sel_out: assert property (@(posedge CLK_I) // [RULE4]
        disable iff (!RSTN_I) WR_I && sel_c2 |=> ##1
        TIMING_PULSE_SELECT_O == $past(WDATA_I[3], 2))
        else $error("timing select wrong");
    a_mal_flag_set: assert property (@(posedge CLK_I) // [RULE3]
        disable iff (!RSTN_I) mal_hit |=> cfg_mal_r)
        else $error("malfunction flag not set");
    a_c2_readback: assert property (@(posedge CLK_I) // [RULE3]
        disable iff (!RSTN_I) RD_I && sel_c2 |=>
        RDATA_O[0] == $past(cfg_mal_r))
        else $error("malfunction readback wrong");
    a_dpg_rise_only: assert property (@(posedge CLK_I) // [RULE6]
        disable iff (!RSTN_I) h_dpg && !c1_r[1] |-> DRUM_PHASE_INPUT_I)
        else $error("rising edge select wrong");
    a_dpg_fall_only: assert property (@(posedge CLK_I) // [RULE6]
        disable iff (!RSTN_I) h_dpg && c1_r[1] |-> !DRUM_PHASE_INPUT_I)
        else $error("falling edge select wrong");
    a_dpg_flag_read: assert property (@(posedge CLK_I) // [RULE1]
        disable iff (!RSTN_I) RD_I && sel_c1 |=>
        RDATA_O[0] == $past(dpg_flag_r))
        else $error("drum phase flag readback wrong");
    a_c1_wonly_zero: assert property (@(posedge CLK_I) // [RULE2]
        disable iff (!RSTN_I) RD_I && sel_c1 |=> RDATA_O[7:1] == 7'h00)
        else $error("write-only bits read back");
    a_mal_flag_clr: assert property (@(posedge CLK_I)
        disable iff (!RSTN_I) cfg_clr && !mal_hit |=> !cfg_mal_r)
        else $error("malfunction flag not cleared");
    a_rdata_idle: assert property (@(posedge CLK_I)
        disable iff (!RSTN_I) !RD_I |=> RDATA_O == 8'h00)
        else $error("read data not idle");
endmodule

// file: testbench/sic_sensor_model.sv
`timescale 1ns/1ps
module sic_sensor_model
(
    input wire logic clk_i,
    output logic [4:0] lvl_o
);
    // 0 drum freq, 1 drum phase, 2 capstan, 3 ctrl track, 4 external
    initial lvl_o = 5'h00;
    // level changes after an edge, then holds long enough to be seen
    task automatic drive(input int i, input logic v);
        @(posedge clk_i);
        lvl_o[i] <= v;
        repeat (5) @(posedge clk_i);
    endtask
endmodule

// file: testbench/servo_input_control_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) \
    begin \
        samples_checked++; \
        if ((g) !== (e)) \
        begin \
            bad_count++; \
            $display("ERROR %s exp %h got %h", n, e, g); \
        end \
    end
module servo_input_control_tb;
    import sic_pkg::*;
    logic CLK_I = 0;
    logic RSTN_I = 0;
    logic WR_I = 0;
    logic RD_I = 0;
    logic [15:0] ADDR_I = 16'h0000;
    sic_byte_t WDATA_I = 8'h00;
    sic_byte_t RDATA_O;
    sic_byte_t d;
    logic [4:0] lvl;
    wire [4:0] edg;
    logic DRUM_SYNC_ON_O;
    logic TIMING_PULSE_SELECT_O;
    int bad_count = 0;
    int samples_checked = 0;
    int cyc = 0;
    int c;
    int cnt[5] = '{0, 0, 0, 0, 0};
    int idx[3] = '{0, 1, 4};

    sic_sensor_model i_sen (.clk_i(CLK_I), .lvl_o(lvl));
    sic_top #(.CFG_TIMEOUT(16'h0014)) i_dut (
        .CLK_I(CLK_I), .RSTN_I(RSTN_I), .ADDR_I(ADDR_I),
        .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
        .DRUM_FREQUENCY_INPUT_I(lvl[0]), .DRUM_PHASE_INPUT_I(lvl[1]),
        .CAPSTAN_FREQUENCY_INPUT_I(lvl[2]),
        .CONTROL_TRACK_INPUT_I(lvl[3]), .EXTERNAL_INPUT_I(lvl[4]),
        .CSYNC_INPUT_I(1'b0), .DRUM_FREQ_EDGE_O(edg[0]),
        .DRUM_PHASE_EDGE_O(edg[1]), .CAPSTAN_EDGE_O(edg[2]),
        .CONTROL_TRACK_EDGE_O(edg[3]), .EXTERNAL_EDGE_O(edg[4]),
        .DRUM_SYNC_ON_O(DRUM_SYNC_ON_O),
        .TIMING_PULSE_SELECT_O(TIMING_PULSE_SELECT_O));

    initial
    begin
        forever #2 CLK_I = ~CLK_I;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // edge pulse tally, plus hang guard
    always @(posedge CLK_I)
    begin
        cyc++;
        for (int i = 0; i < 5; i++)
            if (edg[i] === 1'b1)
                cnt[i]++;
        if (cyc == 3000)
        begin
            bad_count++;
            $display("ERROR run_length exp below 3000 got %0d", cyc);
            end_sim();
        end
    end

    task automatic wr(input logic [15:0] a, input sic_byte_t v);
        @(posedge CLK_I);
        WR_I <= 1'b1;
        ADDR_I <= a;
        WDATA_I <= v;
        @(posedge CLK_I);
        WR_I <= 1'b0;
    endtask

    task automatic rchk(input logic [15:0] a, input sic_byte_t e);
        @(posedge CLK_I);
        RD_I <= 1'b1;
        ADDR_I <= a;
        @(posedge CLK_I);
        RD_I <= 1'b0;
        #1 d = RDATA_O;
        `CHK("rdata", e, d)
    endtask

    task automatic ctl_chk(input logic e, input logic tp);
        repeat (2) @(posedge CLK_I);
        #1 `CHK("ctl_out", {e, tp}, {DRUM_SYNC_ON_O, TIMING_PULSE_SELECT_O})
    endtask

    initial
    begin
        repeat (10) @(posedge CLK_I);
        RSTN_I <= 1'b1;
        ctl_chk(1'b0, 1'b0);
        rchk(16'hffff, 8'h00);
        rchk(16'hffee, 8'h00);
        rchk(16'h1234, 8'h00);
        $display("test reset end");
        wr(16'hffff, 8'h08);
        ctl_chk(1'b0, 1'b1);
        rchk(16'hffff, 8'h08);
        wr(16'hffff, 8'h00);
        wr(16'hffee, 8'h04);
        ctl_chk(1'b1, 1'b0);
        rchk(16'hffee, 8'h00);
        wr(16'hffee, 8'h00);
        ctl_chk(1'b0, 1'b0);
        $display("test control end");
        wr(16'hffee, 8'h66);
        wr(16'hffff, 8'h08);
        wr(16'hffce, 8'h02);
        wr(16'hffef, 8'he0);
        rchk(16'hffce, 8'h02);
        rchk(16'hffef, 8'hc0);
        ctl_chk(1'b1, 1'b1);
        @(posedge CLK_I);
        RSTN_I <= 1'b0;
        repeat (2) @(posedge CLK_I);
        RSTN_I <= 1'b1;
        ctl_chk(1'b0, 1'b0);
        rchk(16'hffff, 8'h00);
        rchk(16'hffce, 8'h00);
        rchk(16'hffef, 8'h00);
        $display("test mid reset end");
        for (int s = 0; s < 2; s++)
        begin
            if (s != 0)
                wr(16'hffee, 8'h62);
            foreach (idx[k])
            begin
                c = cnt[idx[k]];
                i_sen.drive(idx[k], 1'b1);
                `CHK("edge_rise", c + 1 - s, cnt[idx[k]])
                i_sen.drive(idx[k], 1'b0);
                `CHK("edge_fall", c + 1, cnt[idx[k]])
            end
        end
        $display("test edges end");
        rchk(16'hffee, 8'h01);
        wr(16'hfffe, 8'h00);
        rchk(16'hffee, 8'h01);
        wr(16'hfffe, 8'h04);
        rchk(16'hffee, 8'h00);
        i_sen.drive(1, 1'b1);
        rchk(16'hffee, 8'h00);
        i_sen.drive(1, 1'b0);
        rchk(16'hffee, 8'h01);
        wr(16'hfffe, 8'h04);
        wr(16'hffce, 8'h02);
        i_sen.drive(1, 1'b1);
        i_sen.drive(1, 1'b0);
        rchk(16'hffee, 8'h00);
        wr(16'hffce, 8'h00);
        $display("test flag end");
        c = cnt[3];
        i_sen.drive(3, 1'b1);
        `CHK("ctl_rise", c + 1, cnt[3])
        i_sen.drive(3, 1'b0);
        `CHK("ctl_fall", c + 1, cnt[3])
        c = cnt[2];
        i_sen.drive(2, 1'b1);
        `CHK("cap_rise", c + 1, cnt[2])
        i_sen.drive(2, 1'b0);
        `CHK("cap_fall", c + 2, cnt[2])
        repeat (30) @(posedge CLK_I);
        rchk(16'hffff, 8'h01);
        wr(16'hfffe, 8'h08);
        rchk(16'hffff, 8'h00);
        wr(16'hffee, 8'h08);
        i_sen.drive(2, 1'b1);
        `CHK("cap_rise_only", c + 3, cnt[2])
        i_sen.drive(2, 1'b0);
        `CHK("cap_no_fall", c + 3, cnt[2])
        $display("test capstan end");
        end_sim();
    end
endmodule
